// ==== core/mba_pkg.sv ====
/*
  package of the modulo and bit-reversed address generator: register map,
  control field positions, reset values, addressing modes and the request and
  answer carriers. assumes a 32-bit classic wishbone with byte addressing.
*/
package mba_pkg;
  // register byte offsets
  localparam logic [7:0] MBA_OFS_CTRL = 8'h00;
  localparam logic [7:0] MBA_OFS_XSTART = 8'h04;
  localparam logic [7:0] MBA_OFS_XEND = 8'h08;
  localparam logic [7:0] MBA_OFS_YSTART = 8'h0c;
  localparam logic [7:0] MBA_OFS_YEND = 8'h10;
  localparam logic [7:0] MBA_OFS_BITREV = 8'h14;
  localparam logic [7:0] MBA_OFS_STATUS = 8'h18;
  // addr_mode_control fields
  localparam int MBA_XEN_BIT = 15;
  localparam int MBA_YEN_BIT = 14;
  localparam int MBA_BSEL_LSB = 8;
  localparam int MBA_YSEL_LSB = 4;
  localparam int MBA_XSEL_LSB = 0;
  localparam logic [15:0] MBA_CTRL_WMASK = 16'hcfff;
  // bitrev_control fields
  localparam int MBA_BITREV_ENABLE_BIT = 15;
  localparam logic [3:0] MBA_SEL_OFF = 4'hf;
  // reset values
  localparam logic [15:0] MBA_RST_CTRL = 16'h0000;
  localparam logic [15:0] MBA_RST_ADDR = 16'h0000;
  localparam logic [15:0] MBA_RST_BITREV = 16'h0000;
  // generator indices
  localparam int MBA_GEN_XR = 0;
  localparam int MBA_GEN_XW = 1;
  localparam int MBA_GEN_Y = 2;
  localparam int MBA_NGEN = 3;

  typedef enum logic [3:0] {
    MBA_MODE_INDIRECT = 4'b0001,
    MBA_MODE_POST = 4'b0010,
    MBA_MODE_PRE = 4'b0100,
    MBA_MODE_OFFSET = 4'b1000
  } mba_mode_t;

  typedef struct packed {
    logic valid;
    mba_mode_t mode;
    logic [3:0] reg_sel;
    logic [15:0] ptr;
    logic [15:0] offset;
    logic byte_op;
  } mba_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] effective_address;
    logic [15:0] new_ptr;
    logic circ_hit;
    logic bitrev_hit;
  } mba_rsp_t;
endpackage

// ==== core/mba_agu.sv ====
/*
  modulo (circular buffer) effective-address adjustment for the x read, x write and
  y address generators and bit-reversed pointer update for the x write one, with its control registers on
  a classic wishbone slave. assumes the decoder presents the pointer value,
  its register index, addressing mode and signed modify amount each cycle;
  the adjusted address and pointer follow one clock later.
*/
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mba_agu (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // generator requests and answers, index 0 x read, 1 x write, 2 y
  input wire mba_pkg::mba_req_t [2:0] req_i,
  output mba_pkg::mba_rsp_t [2:0] rsp_o
);
  import mba_pkg::*;

  logic [15:0] ctrl_reg;
  logic [15:0] xstart_reg;
  logic [15:0] xend_reg;
  logic [15:0] ystart_reg;
  logic [15:0] yend_reg;
  logic [15:0] bitrev_reg;
  logic [15:0] last_xw_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  mba_rsp_t [2:0] rsp_reg;

  // circular correction; sum is the signed 18-bit pointer plus modifier
  function automatic logic [15:0] mba_circ_fix(input logic signed [17:0] sum,
      input logic [15:0] lo, input logic [15:0] hi);
    logic [17:0] lo_x;
    logic [17:0] hi_x;
    logic [17:0] len;
    logic [17:0] diff;
    logic bidir;
    logic dec;
    logic [17:0] res;
    logic [17:0] span;
    lo_x = {2'b00, lo};
    hi_x = {2'b00, hi};
    len = hi_x - lo_x + 18'h00001;
    // alignment is judged on the next power of two, not on the length itself
    span = len - 18'h00001;
    span = span | (span >> 1);
    span = span | (span >> 2);
    span = span | (span >> 4);
    span = span | (span >> 8);
    span = span | (span >> 16);
    diff = 18'h00000;
    dec = 1'b0;
    res = sum;
    bidir = ((len & (len - 18'h00001)) == 18'h00000) &&
            ((lo_x & (len - 18'h00001)) == 18'h00000);
    if (hi_x >= lo_x) begin
      // direction follows the incrementing/decrementing alignment of the buffer
      dec = (lo[0] != 1'b0) || ((lo_x & span) != 18'h00000);
      if ((!dec || bidir) && (sum > $signed(hi_x))) begin
        diff = 18'(sum - $signed(lo_x));
        res = lo_x + (diff % len);
      end
      if ((dec || bidir) && (sum < $signed(lo_x))) begin
        diff = 18'($signed(hi_x) - sum);
        res = hi_x - (diff % len);
      end
    end
    return res[15:0];
  endfunction

  function automatic logic [14:0] mba_rev15(input logic [14:0] v);
    logic [14:0] r;
    r = 15'h0000;
    for (int i = 0; i < 15; i++) begin
      r[i] = v[14 - i];
    end
    return r;
  endfunction

  // control fields
  wire logic x_circ_enable = ctrl_reg[MBA_XEN_BIT];
  wire logic y_circ_enable = ctrl_reg[MBA_YEN_BIT];
  wire logic [3:0] bitrev_pointer_select = ctrl_reg[MBA_BSEL_LSB +: 4];
  wire logic [3:0] y_circ_pointer_select = ctrl_reg[MBA_YSEL_LSB +: 4];
  wire logic [3:0] x_circ_pointer_select = ctrl_reg[MBA_XSEL_LSB +: 4];
  wire logic bitrev_enable = bitrev_reg[MBA_BITREV_ENABLE_BIT];
  wire logic [14:0] bitrev_pivot_modifier = bitrev_reg[14:0];

  // wishbone decode
  wire logic wb_req = wb_cyc_i && wb_stb_i;
  wire logic wb_wr = wb_req && wb_we_i && ack_reg;
  wire logic [15:0] wb_wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic hit_ctrl = wb_adr_i == MBA_OFS_CTRL;
  wire logic hit_xstart = wb_adr_i == MBA_OFS_XSTART;
  wire logic hit_xend = wb_adr_i == MBA_OFS_XEND;
  wire logic hit_ystart = wb_adr_i == MBA_OFS_YSTART;
  wire logic hit_yend = wb_adr_i == MBA_OFS_YEND;
  wire logic hit_bitrev = wb_adr_i == MBA_OFS_BITREV;
  wire logic hit_status = wb_adr_i == MBA_OFS_STATUS;
  wire logic [15:0] rd_mux =
      hit_ctrl ? ctrl_reg :
      hit_xstart ? xstart_reg :
      hit_xend ? xend_reg :
      hit_ystart ? ystart_reg :
      hit_yend ? yend_reg :
      hit_bitrev ? bitrev_reg :
      hit_status ? last_xw_reg : 16'h0000;

  function automatic logic [15:0] mba_merge(input logic [15:0] old,
      input logic [15:0] nw, input logic [15:0] m);
    return (old & ~m) | (nw & m);
  endfunction

  wire logic [15:0] ctrl_next = mba_merge(ctrl_reg, wb_dat_i[15:0], wb_wmask) &
                                MBA_CTRL_WMASK;
  wire logic ack_next = wb_req && !ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else begin
      ack_reg <= ack_next;
      rdat_reg <= {16'h0000, rd_mux};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= MBA_RST_CTRL;
      xstart_reg <= MBA_RST_ADDR;
      xend_reg <= MBA_RST_ADDR;
      ystart_reg <= MBA_RST_ADDR;
      yend_reg <= MBA_RST_ADDR;
      bitrev_reg <= MBA_RST_BITREV;
    end else if (wb_wr) begin
      if (hit_ctrl) begin
        ctrl_reg <= ctrl_next;
      end
      if (hit_xstart) begin
        xstart_reg <= mba_merge(xstart_reg, wb_dat_i[15:0], wb_wmask);
      end
      if (hit_xend) begin
        xend_reg <= mba_merge(xend_reg, wb_dat_i[15:0], wb_wmask);
      end
      if (hit_ystart) begin
        ystart_reg <= mba_merge(ystart_reg, wb_dat_i[15:0], wb_wmask);
      end
      if (hit_yend) begin
        yend_reg <= mba_merge(yend_reg, wb_dat_i[15:0], wb_wmask);
      end
      if (hit_bitrev) begin
        bitrev_reg <= mba_merge(bitrev_reg, wb_dat_i[15:0], wb_wmask);
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  wire mba_rsp_t [2:0] rsp_next;

  for (genvar g = 0; g < MBA_NGEN; g++) begin : gen_unit
    wire logic circ_en = (g == MBA_GEN_Y) ? y_circ_enable : x_circ_enable;
    wire logic [3:0] circ_sel = (g == MBA_GEN_Y) ? y_circ_pointer_select :
                                x_circ_pointer_select;
    wire logic [15:0] lo = (g == MBA_GEN_Y) ? ystart_reg : xstart_reg;
    wire logic [15:0] hi = (g == MBA_GEN_Y) ? yend_reg : xend_reg;
    wire mba_req_t rq = req_i[g];
    wire logic is_pre = rq.mode == MBA_MODE_PRE;
    wire logic is_post = rq.mode == MBA_MODE_POST;
    wire logic is_offset = rq.mode == MBA_MODE_OFFSET;
    wire logic signed [17:0] sum = $signed({2'b00, rq.ptr}) +
                                   $signed({{2{rq.offset[15]}}, rq.offset});
    wire logic bitrev_on = (g == MBA_GEN_XW) && bitrev_enable &&
                           (bitrev_pointer_select != MBA_SEL_OFF) &&
                           (rq.reg_sel == bitrev_pointer_select) && is_post &&
                           !rq.offset[15] && (rq.offset != 16'h0000) && !rq.byte_op;
    wire logic circ_on = circ_en && (circ_sel != MBA_SEL_OFF) &&
                         (rq.reg_sel == circ_sel) && (is_pre || is_post) && !bitrev_on;
    wire logic [15:0] fixed = circ_on ? mba_circ_fix(sum, lo, hi) : sum[15:0];
    wire logic [14:0] rev_word = mba_rev15(mba_rev15(rq.ptr[15:1]) +
                                           mba_rev15(bitrev_pivot_modifier));
    wire logic [15:0] rev_ptr = {rev_word, 1'b0};
    wire logic [15:0] ea_plain = is_pre ? fixed : (is_offset ? sum[15:0] : rq.ptr);
    wire logic [15:0] ptr_plain = (is_pre || is_post) ? fixed : rq.ptr;
    wire logic word_force = (g == MBA_GEN_Y) && circ_on;
    wire logic [15:0] ea_sel = bitrev_on ? {rq.ptr[15:1], 1'b0} : ea_plain;
    wire logic [15:0] ptr_sel = bitrev_on ? rev_ptr : ptr_plain;
    assign rsp_next[g].valid = rq.valid;
    assign rsp_next[g].effective_address = word_force ? {ea_sel[15:1], 1'b0} : ea_sel;
    assign rsp_next[g].new_ptr = word_force ? {ptr_sel[15:1], 1'b0} : ptr_sel;
    assign rsp_next[g].circ_hit = rq.valid && circ_on;
    assign rsp_next[g].bitrev_hit = rq.valid && bitrev_on;
  end

  // answers are registered every clock; the x write address is held until the next x write request so the status read is stable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_reg <= '0;
      last_xw_reg <= MBA_RST_ADDR;
    end else begin
      rsp_reg <= rsp_next;
      if (rsp_next[MBA_GEN_XW].valid) begin
        last_xw_reg <= rsp_next[MBA_GEN_XW].effective_address;
      end
    end
  end

  assign rsp_o = rsp_reg;
endmodule
`default_nettype wire

// ==== test/mba_agu_monitor.sv ====
/*
  checker beside the address generator: bus handshake and generator answers.
  assumes the one-clock registered answer timing of the block.
*/
`timescale 1ns/1ps
`default_nettype none
module mba_agu_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // generators
  input wire mba_pkg::mba_req_t [2:0] req_i,
  input wire mba_pkg::mba_rsp_t [2:0] rsp_o
);
  import mba_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // answers right after reset come from the reset itself, so skip them
  sequence s_live;
    !$past(rst_i);
  endsequence
  AST_ACK_NEXT: assert property (s_bus_req |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  AST_CTRL_RSV: assert property (wb_ack_o && !wb_we_i && wb_adr_i == MBA_OFS_CTRL |-> wb_dat_o[13:12] == 2'h0)
    else $error("reserved control bits read nonzero");
  AST_REV_WRITE_ONLY: assert property (!rsp_o[0].bitrev_hit && !rsp_o[2].bitrev_hit)
    else $error("bit reversal on a read generator");
  AST_REV_WORD: assert property (rsp_o[1].bitrev_hit |-> !rsp_o[1].effective_address[0] && !rsp_o[1].new_ptr[0])
    else $error("bit reversed address not word aligned");
  AST_REV_MODE: assert property (s_live ##0 rsp_o[1].bitrev_hit |-> $past(req_i[1].mode) == MBA_MODE_POST && !$past(req_i[1].byte_op))
    else $error("bit reversal outside word post-increment");
  AST_REV_PRIO: assert property (rsp_o[1].bitrev_hit |-> !rsp_o[1].circ_hit)
    else $error("modulo applied with bit reversal");
  AST_OFS_PLAIN: assert property (s_live ##0 $past(req_i[0].mode) == MBA_MODE_OFFSET |-> !rsp_o[0].circ_hit && rsp_o[0].new_ptr == $past(req_i[0].ptr))
    else $error("register offset access corrected");
  AST_INDIRECT: assert property (s_live ##0 $past(req_i[0].mode) == MBA_MODE_INDIRECT |-> rsp_o[0].effective_address == $past(req_i[0].ptr))
    else $error("plain indirect address altered");
  AST_Y_WORD: assert property (rsp_o[2].circ_hit |-> !rsp_o[2].effective_address[0])
    else $error("y corrected address odd");
endmodule
bind mba_agu mba_agu_monitor i_mba_agu_monitor (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_i(req_i), .rsp_o(rsp_o));
`default_nettype wire

// ==== test/mba_core_model.sv ====
/*
  core side model: the decoder presents one request and takes its answer.
  assumes the answer stands one clock after the request.
*/
`timescale 1ns/1ps
`default_nettype none
module mba_core_model (
  // clock
  input wire logic clk_i,
  // generator requests and answers
  output mba_pkg::mba_req_t [2:0] req_o,
  input wire mba_pkg::mba_rsp_t [2:0] rsp_i
);
  import mba_pkg::*;
  initial req_o = '0;
  task automatic issue(input int g, input mba_req_t r, output mba_rsp_t s);
    @(posedge clk_i);
    req_o[g] <= r;
    @(posedge clk_i);
    // released slot shows the inverse, valid low, so stale data never matches
    req_o[g] <= ~r;
    @(posedge clk_i);
    s = rsp_i[g];
  endtask
endmodule
`default_nettype wire

// ==== test/test_mba_agu.sv ====
/*
  testbench of the address generator: register access and generator cases.
  assumes the core model drives the generator requests.
*/
`timescale 1ns/1ps
`default_nettype none
module test_mba_agu;
  import mba_pkg::*;
  localparam mba_mode_t m_post = MBA_MODE_POST;
  localparam mba_mode_t m_pre = MBA_MODE_PRE;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, rs;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] q, p;
  logic [15:0] tab [4] = '{16'h0010, 16'h0008, 16'h0018, 16'h0004};
  mba_req_t [2:0] req_i;
  mba_rsp_t [2:0] rsp_o;
  int miscompares = 0;
  int checks = 0;
  mba_agu i_mba_agu (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_i(req_i), .rsp_o(rsp_o));
  mba_core_model i_mba_core_model (.clk_i(clk_i), .req_o(req_i), .rsp_i(rsp_o));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk("register", q, e);
  endtask
  task automatic gen(input int g, input mba_mode_t m, input logic [15:0] pt, input logic [15:0] o,
      input logic [15:0] ea, input logic [15:0] np, input logic b = 1'b0);
    mba_rsp_t s;
    i_mba_core_model.issue(g, '{1'b1, m, rs, pt, o, b}, s);
    chk("address", s.effective_address, ea);
    chk("pointer", s.new_ptr, np);
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'h3;
    rs = 4'h2;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(MBA_OFS_CTRL, 16'h0000);
    rd(MBA_OFS_XSTART, 16'h0000);
    wr(MBA_OFS_CTRL, 16'hffff);
    rd(MBA_OFS_CTRL, 16'hcfff);
    wr(MBA_OFS_XSTART, 16'ha5a5);
    rd(MBA_OFS_XSTART, 16'ha5a5);
    rd(8'h1c, 16'h0000);
    $display("test registers done");
    wr(MBA_OFS_XSTART, 16'h2000);
    wr(MBA_OFS_XEND, 16'h2063);
    wr(MBA_OFS_CTRL, 16'h8ff2);
    gen(0, m_post, 16'h2062, 16'h0002, 16'h2062, 16'h2000);
    gen(1, m_pre, 16'h2000, 16'h00ca, 16'h2002, 16'h2002);
    gen(0, m_pre, 16'h2000, 16'hfffe, 16'h1ffe, 16'h1ffe);
    gen(0, MBA_MODE_OFFSET, 16'h2062, 16'h0002, 16'h2064, 16'h2062);
    gen(0, MBA_MODE_INDIRECT, 16'h2062, 16'h0002, 16'h2062, 16'h2062);
    rs = 4'h3;
    gen(0, m_post, 16'h2062, 16'h0002, 16'h2062, 16'h2064);
    rs = 4'h2;
    wr(MBA_OFS_CTRL, 16'h0ff2);
    gen(0, m_post, 16'h2062, 16'h0002, 16'h2062, 16'h2064);
    wr(MBA_OFS_XSTART, 16'h201c);
    wr(MBA_OFS_XEND, 16'h207f);
    wr(MBA_OFS_CTRL, 16'h8ff2);
    gen(0, m_pre, 16'h201c, 16'hfffc, 16'h207c, 16'h207c);
    gen(1, m_post, 16'h207e, 16'h0002, 16'h207e, 16'h2080);
    wr(MBA_OFS_XSTART, 16'h2000);
    wr(MBA_OFS_XEND, 16'h201f);
    gen(0, m_pre, 16'h2000, 16'hfffe, 16'h201e, 16'h201e);
    gen(1, m_post, 16'h201e, 16'h0004, 16'h201e, 16'h2002);
    $display("test modulo x done");
    wr(MBA_OFS_YSTART, 16'h3000);
    wr(MBA_OFS_YEND, 16'h300f);
    wr(MBA_OFS_CTRL, 16'h4f3f);
    rs = 4'h3;
    gen(2, m_pre, 16'h300e, 16'h0002, 16'h3000, 16'h3000);
    rs = 4'h4;
    gen(2, m_pre, 16'h300e, 16'h0002, 16'h3010, 16'h3010);
    $display("test modulo y done");
    wr(MBA_OFS_XSTART, 16'h0000);
    wr(MBA_OFS_XEND, 16'h001f);
    wr(MBA_OFS_BITREV, 16'h8008);
    wr(MBA_OFS_CTRL, 16'h85f5);
    rs = 4'h5;
    p = 16'h0000;
    foreach (tab[i]) begin
      gen(1, m_post, p, 16'h0002, p, tab[i]);
      p = tab[i];
    end
    gen(1, m_post, 16'h0011, 16'h0002, 16'h0010, 16'h0008);
    gen(1, m_post, 16'h0010, 16'h0006, 16'h0010, 16'h0008);
    gen(1, m_post, 16'h0010, 16'h0001, 16'h0010, 16'h0011, 1'b1);
    gen(1, m_pre, 16'h0010, 16'h0002, 16'h0012, 16'h0012);
    gen(0, m_post, 16'h0010, 16'h0002, 16'h0010, 16'h0012);
    gen(0, m_post, 16'h001e, 16'h0002, 16'h001e, 16'h0000);
    wr(MBA_OFS_CTRL, 16'h0ff5);
    gen(1, m_post, 16'h0010, 16'h0002, 16'h0010, 16'h0012);
    $display("test bit reversal done");
    complete_run();
  end
endmodule
`default_nettype wire
